/* rtl/cids_datapath.sv */
// Execution datapath for a subset of a 32-bit core's instruction set.
// Assumes a classic Wishbone master on the same clock; one op per CTRL write.
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "cids_consts.svh"

module cids_datapath
  import cids_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);

  // ========================================================================
  // Bus slave
  logic         busReq;
  logic         busWrite;
  logic [31:0]  opA;
  logic [31:0]  opB;
  logic [31:0]  opC;
  logic [31:0]  opD;
  cids_ctrl_t   ctrl;
  logic [31:0]  resLo;
  logic [31:0]  resHi;
  cids_status_t status;
  logic         launch;

  assign busReq   = wb_cyc_i & wb_stb_i;
  assign busWrite = busReq & wb_ack_o & wb_we_i;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] upd,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = upd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq & ~wb_ack_o;
    end
  end

  // Unmapped addresses still acknowledge and read as zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= `CIDS_RST_WORD;
    end else if (busReq & ~wb_ack_o) begin
      case (wb_adr_i)
        `CIDS_OFS_OPA:   wb_dat_o <= opA;
        `CIDS_OFS_OPB:   wb_dat_o <= opB;
        `CIDS_OFS_OPC:   wb_dat_o <= opC;
        `CIDS_OFS_OPD:   wb_dat_o <= opD;
        `CIDS_OFS_CTRL:  wb_dat_o <= ctrl;
        `CIDS_OFS_RESLO: wb_dat_o <= resLo;
        `CIDS_OFS_RESHI: wb_dat_o <= resHi;
        `CIDS_OFS_FLAGS: wb_dat_o <= status & 32'hf80f_f001;
        default:         wb_dat_o <= `CIDS_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      opA <= `CIDS_RST_WORD;
      opB <= `CIDS_RST_WORD;
      opC <= `CIDS_RST_WORD;
      opD <= `CIDS_RST_WORD;
    end else if (busWrite) begin
      if (wb_adr_i == `CIDS_OFS_OPA) opA <= merge(opA, wb_dat_i, wb_sel_i);
      if (wb_adr_i == `CIDS_OFS_OPB) opB <= merge(opB, wb_dat_i, wb_sel_i);
      if (wb_adr_i == `CIDS_OFS_OPC) opC <= merge(opC, wb_dat_i, wb_sel_i);
      if (wb_adr_i == `CIDS_OFS_OPD) opD <= merge(opD, wb_dat_i, wb_sel_i);
    end
  end

  // A CTRL write starts the operation on the following cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl   <= cids_ctrl_t'(`CIDS_RST_WORD);
      launch <= 1'b0;
    end else begin
      launch <= busWrite & (wb_adr_i == `CIDS_OFS_CTRL);
      if (busWrite & (wb_adr_i == `CIDS_OFS_CTRL)) begin
        ctrl <= cids_ctrl_t'(merge(ctrl, wb_dat_i, wb_sel_i));
      end
    end
  end

  // ========================================================================
  // Lane arithmetic
  logic [16:0] hRes [2];
  logic [15:0] hOut [2];
  logic [1:0]  hGe;
  logic [8:0]  bRes [4];
  logic [7:0]  bOut [4];
  logic [3:0]  bGe;
  logic [7:0]  absDiff [4];

  for (genvar i = 0; i < 2; i++) begin : g_half
    logic        sub;
    logic [15:0] bLane;
    assign sub = (ctrl.laneKind == CIDS_LK_SUB) ||
                 (ctrl.laneKind == CIDS_LK_ADD_SUB_X && i == 0) ||
                 (ctrl.laneKind == CIDS_LK_SUB_ADD_X && i == 1);
    assign bLane = ctrl.laneKind[1] ? opB[16*(1-i) +: 16] : opB[16*i +: 16];
    assign hRes[i] = sub ? {1'b0, opA[16*i +: 16]} - {1'b0, bLane}
                         : {1'b0, opA[16*i +: 16]} + {1'b0, bLane};
    assign hGe[i] = sub ? ~hRes[i][16] : hRes[i][16];
    always_comb begin
      case (ctrl.laneMode)
        CIDS_LM_HALVING:    hOut[i] = hRes[i][16:1];
        CIDS_LM_SATURATING: begin
          if (hRes[i][16]) begin
            hOut[i] = sub ? 16'h0000 : 16'hffff;
          end else begin
            hOut[i] = hRes[i][15:0];
          end
        end
        default:            hOut[i] = hRes[i][15:0];
      endcase
    end
  end

  // Byte lanes have no exchange form; those kinds act as plain add
  for (genvar j = 0; j < 4; j++) begin : g_byte
    logic sub;
    assign sub = (ctrl.laneKind == CIDS_LK_SUB);
    assign bRes[j] = sub ? {1'b0, opA[8*j +: 8]} - {1'b0, opB[8*j +: 8]}
                         : {1'b0, opA[8*j +: 8]} + {1'b0, opB[8*j +: 8]};
    assign bGe[j] = sub ? ~bRes[j][8] : bRes[j][8];
    assign absDiff[j] = (opA[8*j +: 8] > opB[8*j +: 8]) ?
                        opA[8*j +: 8] - opB[8*j +: 8] :
                        opB[8*j +: 8] - opA[8*j +: 8];
    always_comb begin
      case (ctrl.laneMode)
        CIDS_LM_HALVING:    bOut[j] = bRes[j][8:1];
        CIDS_LM_SATURATING: begin
          if (bRes[j][8]) begin
            bOut[j] = sub ? 8'h00 : 8'hff;
          end else begin
            bOut[j] = bRes[j][7:0];
          end
        end
        default:            bOut[j] = bRes[j][7:0];
      endcase
    end
  end

  // ========================================================================
  // Floating point helpers
  function automatic logic isNan(input logic [31:0] f);
    return (f[30:23] == 8'hff) && (f[22:0] != 23'h0);
  endfunction

  function automatic logic [3:0] fpCmp(input logic [31:0] x,
                                       input logic [31:0] y);
    logic [31:0] kx;
    logic [31:0] ky;
    if (isNan(x) || isNan(y)) begin
      return `CIDS_CMP_UNORD;
    end
    if ((x[30:0] == 31'h0) && (y[30:0] == 31'h0)) begin
      return `CIDS_CMP_EQUAL;
    end
    // Sign-magnitude mapped to an ordered unsigned key
    kx = x[31] ? ~x : {1'b1, x[30:0]};
    ky = y[31] ? ~y : {1'b1, y[30:0]};
    if (kx == ky) begin
      return `CIDS_CMP_EQUAL;
    end
    return (kx < ky) ? `CIDS_CMP_LESS : `CIDS_CMP_GREATER;
  endfunction

  // Truncates toward zero; out of range saturates and flags invalid
  function automatic logic [32:0] fpToInt(input logic [31:0] f);
    logic [7:0]  e;
    logic [31:0] mag;
    e = f[`CIDS_FP_EXP_HI:`CIDS_FP_EXP_LO];
    mag = 32'h0;
    if (isNan(f)) begin
      return {1'b1, 32'h0};
    end
    if (e < `CIDS_FP_BIAS) begin
      return {1'b0, 32'h0};
    end
    if (e >= 8'h9e) begin
      if (f == 32'hcf00_0000) begin
        return {1'b0, 32'h8000_0000};
      end
      return {1'b1, f[`CIDS_FP_SIGN] ? 32'h8000_0000 : 32'h7fff_ffff};
    end
    if (e >= 8'h96) begin
      mag = {8'h00, 1'b1, f[22:0]} << (e - 8'h96);
    end else begin
      mag = {8'h00, 1'b1, f[22:0]} >> (8'h96 - e);
    end
    return {1'b0, f[`CIDS_FP_SIGN] ? 32'(-mag) : mag};
  endfunction

  // Conversion to float truncates low bits that do not fit
  function automatic logic [31:0] intToFp(input logic [31:0] v);
    logic [31:0] mag;
    logic [4:0]  top;
    logic [31:0] norm;
    mag = v[31] ? 32'(-v) : v;
    top = 5'd0;
    for (int k = 0; k < 32; k++) begin
      if (mag[k]) begin
        top = 5'(k);
      end
    end
    if (mag == 32'h0) begin
      return 32'h0;
    end
    norm = mag << (5'd31 - top);
    return {v[31], 8'(top) + `CIDS_FP_BIAS, norm[30:8]};
  endfunction

  // ========================================================================
  // Operation select
  logic [31:0] rotB;
  logic [63:0] next_wide;
  logic [3:0]  next_ge;
  logic        geUpd;
  logic [3:0]  next_fpNzcv;
  logic        fpUpd;
  logic        setInvalid;
  logic        resUpd;
  logic [32:0] cvt;
  logic [47:0] wordHalf;
  logic [31:0] fieldMask;
  logic [31:0] cmpRhs;

  assign rotB = 32'({opB, opB} >> {ctrl.rotate, 3'b000});
  assign wordHalf = $signed(opA) *
                    $signed(ctrl.exchange ? opB[31:16] : opB[15:0]);
  assign fieldMask = 32'hffff_ffff >> (5'd31 - ctrl.fieldWidthM1);
  assign cvt = fpToInt(opA);
  assign cmpRhs = ctrl.cmpZero ? 32'h0 : opB;

  always_comb begin
    logic [31:0] bx;
    logic [31:0] lo;
    logic [31:0] hi;
    bx = ctrl.exchange ? {opB[15:0], opB[31:16]} : opB;
    lo = 32'(signed'({opA[31], opA[31:16]}) + signed'({bx[15], bx[15:0]}));
    hi = 32'(signed'({opA[15], opA[15:0]}) - signed'({bx[31], bx[31:16]}));
    next_wide   = {resHi, resLo};
    next_ge     = status.laneGeFlags;
    geUpd       = 1'b0;
    next_fpNzcv = status.fpNzcv;
    fpUpd       = 1'b0;
    setInvalid  = 1'b0;
    resUpd      = 1'b1;
    case (ctrl.op)
      CIDS_OP_UMUL_ACC_LONG: begin
        next_wide = opA * opB + {opD, opC};
      end
      CIDS_OP_UMUL_DOUBLE_ACC_LONG: begin
        next_wide = opA * opB + {32'h0, opC} + {32'h0, opD};
      end
      CIDS_OP_SMUL_WORD_HALFWORD: begin
        next_wide = {32'h0, wordHalf[47:16]};
      end
      CIDS_OP_SDUAL_MUL_SUB: begin
        next_wide = {32'h0, 32'($signed(opA[15:0]) * $signed(bx[15:0])
                     - $signed(opA[31:16]) * $signed(bx[31:16]))};
      end
      CIDS_OP_S_SUB_ADD_EXCHANGE: begin
        // Top lane subtracts low half of B, bottom adds high half
        lo = 32'($signed(opA[15:0]) + $signed(opB[31:16]));
        hi = 32'($signed(opA[31:16]) - $signed(opB[15:0]));
        next_wide = {32'h0, hi[15:0], lo[15:0]};
        next_ge = {{2{~hi[16]}}, {2{~lo[16]}}};
        geUpd = 1'b1;
      end
      CIDS_OP_U_LANES: begin
        if (ctrl.laneByte) begin
          next_wide = {32'h0, bOut[3], bOut[2], bOut[1], bOut[0]};
          next_ge = bGe;
        end else begin
          next_wide = {32'h0, hOut[1], hOut[0]};
          next_ge = {{2{hGe[1]}}, {2{hGe[0]}}};
        end
        geUpd = (ctrl.laneMode == CIDS_LM_PLAIN);
      end
      CIDS_OP_ABS_DIFF_SUM: begin
        next_wide = {32'h0, 32'(absDiff[0] + absDiff[1] + absDiff[2]
                     + absDiff[3]) + (ctrl.accum ? opC : 32'h0)};
      end
      CIDS_OP_SIGN_EXT_HALF: begin
        next_wide = {32'h0, {16{rotB[15]}}, rotB[15:0]};
      end
      CIDS_OP_ZERO_EXT_HALF: begin
        next_wide = {32'h0, 16'h0000, rotB[15:0]};
      end
      CIDS_OP_ZERO_EXT_BYTE_ADD: begin
        next_wide = {32'h0, opA + {24'h0, rotB[7:0]}};
      end
      CIDS_OP_DUAL_SIGN_EXT_BYTE_ADD: begin
        lo = {16'h0, opA[15:0] + {{8{rotB[7]}}, rotB[7:0]}};
        hi = {16'h0, opA[31:16] + {{8{rotB[23]}}, rotB[23:16]}};
        next_wide = {32'h0, hi[15:0], lo[15:0]};
      end
      CIDS_OP_UNSIGNED_FIELD_EXTRACT: begin
        next_wide = {32'h0, (opA >> ctrl.fieldLsb) & fieldMask};
      end
      CIDS_OP_STORE_MULTI_DESC: begin
        // Low word: first store address; high word: new base value
        lo = opA - {25'h0, ctrl.regCount, 2'b00};
        next_wide = {ctrl.writeBack ? lo : opA, lo};
      end
      CIDS_OP_STORE_DOUBLE_WORD: begin
        next_wide = {opA + opB + 32'h4, opA + opB};
      end
      CIDS_OP_STORE_EXCL_HALF: begin
        // Bit 16 of the high word marks that memory is written
        next_wide = {15'h0, ctrl.exclHeld,
                     ctrl.exclHeld ? opB[15:0] : 16'h0000,
                     31'h0, ~ctrl.exclHeld};
      end
      CIDS_OP_TABLE_BRANCH_HALF: begin
        next_wide = {opD + {15'h0, opC[15:0], 1'b0},
                     opA + {opB[30:0], 1'b0}};
      end
      CIDS_OP_FP_COMPARE: begin
        resUpd = 1'b0;
        fpUpd = 1'b1;
        next_fpNzcv = fpCmp(opA, cmpRhs);
        if (ctrl.accum) begin
          setInvalid = isNan(opA) || isNan(cmpRhs);
        end else begin
          setInvalid = (isNan(opA) && !opA[`CIDS_FP_QUIET]) ||
                       (isNan(cmpRhs) && !cmpRhs[`CIDS_FP_QUIET]);
        end
      end
      CIDS_OP_FP_TO_INT: begin
        next_wide = {32'h0, cvt[31:0]};
        setInvalid = cvt[32];
      end
      CIDS_OP_INT_TO_FP: begin
        next_wide = {32'h0, intToFp(opA)};
      end
      default: begin
        resUpd = 1'b0;
      end
    endcase
  end

  // ========================================================================
  // Result and flag registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      resLo <= `CIDS_RST_WORD;
      resHi <= `CIDS_RST_WORD;
    end else if (launch & resUpd) begin
      resLo <= next_wide[31:0];
      resHi <= next_wide[63:32];
    end
  end

  // Hardware updates win over a software write in the same cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status <= cids_status_t'(`CIDS_RST_WORD);
    end else begin
      if (busWrite & (wb_adr_i == `CIDS_OFS_FLAGS)) begin
        status <= cids_status_t'(merge(status, wb_dat_i, wb_sel_i)
                                 & 32'hf80f_f001);
      end
      if (launch & geUpd) begin
        status.laneGeFlags <= next_ge;
      end
      if (launch & fpUpd) begin
        status.fpNzcv <= next_fpNzcv;
      end
      if (launch & setInvalid) begin
        status.invalidOp <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  logic flagsWrite;
  assign flagsWrite = busWrite & (wb_adr_i == `CIDS_OFS_FLAGS);

  sequence startOp(cids_op_t o);
    launch && ctrl.op == o;
  endsequence

  busAck_a: assert property (busReq && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
  macLong_a: assert property (startOp(CIDS_OP_UMUL_ACC_LONG) |=>
    {resHi, resLo} == $past(opA) * $past(opB) + {$past(opD), $past(opC)})
    else $error("accumulate long result wrong");
  dblAcc_a: assert property (startOp(CIDS_OP_UMUL_DOUBLE_ACC_LONG) |=>
    {resHi, resLo} == $past(opA) * $past(opB) + $past(opC) + $past(opD))
    else $error("double accumulate result wrong");
  halvingLane_a: assert property (startOp(CIDS_OP_U_LANES) ##0
    (ctrl.laneMode == CIDS_LM_HALVING) |=> $stable(status.laneGeFlags))
    else $error("halving lane op changed lane flags");
  laneFlags_a: assert property (startOp(CIDS_OP_U_LANES) ##0
    (ctrl.laneMode == CIDS_LM_PLAIN && !ctrl.laneByte &&
    ctrl.laneKind == CIDS_LK_ADD) |=>
    status.laneGeFlags[0] == ($past(opA[15:0]) + 17'($past(opB[15:0])) >
    17'h0ffff))
    else $error("lane carry flag wrong");
  keepFlags_a: assert property (!flagsWrite |=>
    $stable(status.intNzcv) && $stable(status.satSticky))
    else $error("integer or sticky flags changed");
  fieldExt_a: assert property (
    startOp(CIDS_OP_UNSIGNED_FIELD_EXTRACT) |=>
    (resLo >> ($past(ctrl.fieldWidthM1) + 6'd1)) == 32'h0)
    else $error("extracted field wider than requested");
  storeDesc_a: assert property (startOp(CIDS_OP_STORE_MULTI_DESC) |=>
    resLo == $past(opA) - 4 * $past(ctrl.regCount) &&
    (!$past(ctrl.writeBack) || resHi == resLo))
    else $error("descending store address wrong");
  exclStore_a: assert property (startOp(CIDS_OP_STORE_EXCL_HALF) |=>
    resLo == {31'h0, !$past(ctrl.exclHeld)} && resHi[16] == !resLo[0])
    else $error("exclusive store status wrong");
  fpInvalid_a: assert property (startOp(CIDS_OP_FP_COMPARE) ##0
    (ctrl.accum && isNan(opA)) |=>
    status.invalidOp && status.fpNzcv == `CIDS_CMP_UNORD)
    else $error("signalling compare missed NaN");

endmodule

/* rtl/cids_consts.svh */
// Register offsets, field positions and reset values for the datapath.
// Assumes a Wishbone slave decoding an 8-bit byte address, word aligned.
`ifndef CIDS_CONSTS_SVH
`define CIDS_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define CIDS_OFS_OPA      8'h00
`define CIDS_OFS_OPB      8'h04
`define CIDS_OFS_OPC      8'h08
`define CIDS_OFS_OPD      8'h0c
`define CIDS_OFS_CTRL     8'h10
`define CIDS_OFS_RESLO    8'h14
`define CIDS_OFS_RESHI    8'h18
`define CIDS_OFS_FLAGS    8'h1c

// ==========================================================================
// Reset values
`define CIDS_RST_WORD     32'h0000_0000

// ==========================================================================
// Single-precision field positions
`define CIDS_FP_SIGN      31
`define CIDS_FP_EXP_HI    30
`define CIDS_FP_EXP_LO    23
`define CIDS_FP_QUIET     22
`define CIDS_FP_BIAS      8'h7f

// Compare outcomes as N,Z,C,V
`define CIDS_CMP_EQUAL    4'h6
`define CIDS_CMP_LESS     4'h8
`define CIDS_CMP_GREATER  4'h2
`define CIDS_CMP_UNORD    4'h3

`endif

/* rtl/cids_pkg.sv */
// Types shared by the datapath: opcodes, lane modes, control and status.
// Assumes the constants header is included by the design file.
package cids_pkg;

  // ========================================================================
  // Operation codes, in CTRL[4:0]
  typedef enum logic [4:0] {
    CIDS_OP_NONE,
    CIDS_OP_UMUL_ACC_LONG,
    CIDS_OP_UMUL_DOUBLE_ACC_LONG,
    CIDS_OP_SMUL_WORD_HALFWORD,
    CIDS_OP_SDUAL_MUL_SUB,
    CIDS_OP_S_SUB_ADD_EXCHANGE,
    CIDS_OP_U_LANES,
    CIDS_OP_ABS_DIFF_SUM,
    CIDS_OP_SIGN_EXT_HALF,
    CIDS_OP_ZERO_EXT_HALF,
    CIDS_OP_ZERO_EXT_BYTE_ADD,
    CIDS_OP_DUAL_SIGN_EXT_BYTE_ADD,
    CIDS_OP_UNSIGNED_FIELD_EXTRACT,
    CIDS_OP_STORE_MULTI_DESC,
    CIDS_OP_STORE_DOUBLE_WORD,
    CIDS_OP_STORE_EXCL_HALF,
    CIDS_OP_TABLE_BRANCH_HALF,
    CIDS_OP_FP_COMPARE,
    CIDS_OP_FP_TO_INT,
    CIDS_OP_INT_TO_FP
  } cids_op_t;

  typedef enum logic [1:0] {
    CIDS_LK_ADD,
    CIDS_LK_SUB,
    CIDS_LK_ADD_SUB_X,
    CIDS_LK_SUB_ADD_X
  } cids_lane_kind_t;

  typedef enum logic [1:0] {
    CIDS_LM_PLAIN,
    CIDS_LM_HALVING,
    CIDS_LM_SATURATING,
    CIDS_LM_SPARE
  } cids_lane_mode_t;

  // ========================================================================
  // Control word
  typedef struct packed {
    cids_lane_kind_t laneKind;     // 31:30
    cids_lane_mode_t laneMode;     // 29:28
    logic            laneByte;     // 27
    logic            exclHeld;     // 26
    logic            cmpZero;      // 25
    logic            writeBack;    // 24
    logic [4:0]      regCount;     // 23:19
    logic [4:0]      fieldWidthM1; // 18:14
    logic [4:0]      fieldLsb;     // 13:9
    logic            accum;        // 8
    logic            exchange;     // 7
    logic [1:0]      rotate;       // 6:5
    cids_op_t        op;           // 4:0
  } cids_ctrl_t;

  // ========================================================================
  // Flag word
  typedef struct packed {
    logic [3:0]  intNzcv;
    logic        satSticky;
    logic [6:0]  rsvHigh;
    logic [3:0]  laneGeFlags;
    logic [3:0]  fpNzcv;
    logic [10:0] rsvLow;
    logic        invalidOp;
  } cids_status_t;

endpackage

/* test/tb_top.sv */
// Self-checking bench for the datapath, driven over its register bus.
// Assumes one clock, async low reset and a one-cycle Wishbone ack.
`timescale 1ns/10ps

module tb_top
  import cids_pkg::*;
;
  logic        clock = 1'b0;
  logic        nrst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datI;
  logic [31:0] datO;
  logic        ack;
  logic [31:0] rd;
  cids_ctrl_t  ctl;
  int          mismatches = 0;
  int          num_checks = 0;

  always #12.5 clock = ~clock;

  cids_datapath uut (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack));

  // ==========================================================================
  // Bus helpers
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    sel <= s;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      $display("CHECK FAILED t=%0t no ack", $time);
    end
    rd = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Idle cycle so the strobe is seen low between requests
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0, 4'hf);
    num_checks++;
    if (rd !== x) begin
      mismatches++;
      $display("CHECK FAILED t=%0t adr %h got %h exp %h", $time, a, rd, x);
    end
  endtask

  task automatic go(input cids_op_t o);
    ctl = '0;
    ctl.op = o;
  endtask

  // Operands first, then the control word launches the op
  task automatic run(input logic [31:0] a, b, c, d);
    wr(8'h00, a);
    wr(8'h04, b);
    wr(8'h08, c);
    wr(8'h0c, d);
    wr(8'h10, ctl);
  endtask

  task automatic lohi(input logic [31:0] lo, hi);
    chk(8'h14, lo);
    chk(8'h18, hi);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    chk(8'h00, 32'h0);
    wr(8'h00, 32'hffff_ffff);
    bus(1'b1, 8'h00, 32'h1234_5678, 4'h2);
    chk(8'h00, 32'hffff_56ff);
    wr(8'h20, 32'hdead_beef);
    chk(8'h20, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_mul;
    wr(8'h1c, 32'hf80f_f001);
    go(CIDS_OP_UMUL_ACC_LONG);
    run(32'hffff_ffff, 32'hffff_ffff, 32'h1, 32'h2);
    lohi(32'h2, 32'h0);
    chk(8'h1c, 32'hf80f_f001);
    wr(8'h14, 32'h5555_5555);
    chk(8'h14, 32'h2);
    go(CIDS_OP_UMUL_DOUBLE_ACC_LONG);
    run(32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff);
    lohi(32'hffff_ffff, 32'hffff_ffff);
    go(CIDS_OP_SDUAL_MUL_SUB);
    run(32'h0003_0002, 32'h0004_0005, 32'h0, 32'h0);
    chk(8'h14, 32'hffff_fffe);
    ctl.exchange = 1'b1;
    wr(8'h10, ctl);
    chk(8'h14, 32'hffff_fff9);
    go(CIDS_OP_SMUL_WORD_HALFWORD);
    run(32'h0001_0000, 32'h0003_fffe, 32'h0, 32'h0);
    lohi(32'hffff_fffe, 32'h0);
    ctl.exchange = 1'b1;
    wr(8'h10, ctl);
    chk(8'h14, 32'h3);
    chk(8'h1c, 32'hf80f_f001);
    go(CIDS_OP_S_SUB_ADD_EXCHANGE);
    run(32'h0005_0003, 32'h0002_0007, 32'h0, 32'h0);
    chk(8'h14, 32'hfffe_0005);
    chk(8'h1c, 32'hf803_f001);
    $display("test mul done");
  endtask

  task automatic t_lanes;
    wr(8'h1c, 32'h0);
    go(CIDS_OP_U_LANES);
    run(32'hffff_0001, 32'h0001_0001, 32'h0, 32'h0);
    chk(8'h14, 32'h0000_0002);
    chk(8'h1c, 32'h000c_0000);
    ctl.laneByte = 1'b1;
    ctl.laneKind = CIDS_LK_SUB;
    run(32'h0102_0304, 32'h0201_0403, 32'h0, 32'h0);
    chk(8'h14, 32'hff01_ff01);
    chk(8'h1c, 32'h0005_0000);
    ctl.laneByte = 1'b0;
    ctl.laneKind = CIDS_LK_ADD_SUB_X;
    run(32'h0005_0003, 32'h0002_0007, 32'h0, 32'h0);
    chk(8'h14, 32'h000c_0001);
    chk(8'h1c, 32'h0003_0000);
    ctl.laneKind = CIDS_LK_SUB_ADD_X;
    wr(8'h10, ctl);
    chk(8'h14, 32'hfffe_0005);
    chk(8'h1c, 32'h0);
    wr(8'h1c, 32'hf80f_f001);
    ctl.laneKind = CIDS_LK_ADD;
    ctl.laneMode = CIDS_LM_HALVING;
    run(32'hffff_0003, 32'h0001_0001, 32'h0, 32'h0);
    chk(8'h14, 32'h8000_0002);
    chk(8'h1c, 32'hf80f_f001);
    wr(8'h1c, 32'h0);
    ctl.laneMode = CIDS_LM_SATURATING;
    wr(8'h10, ctl);
    chk(8'h14, 32'hffff_0004);
    chk(8'h1c, 32'h0);
    $display("test lanes done");
  endtask

  task automatic t_ext;
    go(CIDS_OP_ABS_DIFF_SUM);
    ctl.accum = 1'b1;
    run(32'h01ff_1000, 32'hff01_0010, 32'h5, 32'h0);
    chk(8'h14, 32'h0000_0221);
    go(CIDS_OP_SIGN_EXT_HALF);
    ctl.rotate = 2'h1;
    run(32'h0080_00ff, 32'h0080_00ff, 32'h0, 32'h0);
    chk(8'h14, 32'hffff_8000);
    ctl.op = CIDS_OP_ZERO_EXT_HALF;
    wr(8'h10, ctl);
    chk(8'h14, 32'h0000_8000);
    ctl.op = CIDS_OP_ZERO_EXT_BYTE_ADD;
    run(32'h0000_0100, 32'h0000_ab00, 32'h0, 32'h0);
    chk(8'h14, 32'h0000_01ab);
    go(CIDS_OP_DUAL_SIGN_EXT_BYTE_ADD);
    run(32'h0001_0001, 32'h0080_00ff, 32'h0, 32'h0);
    chk(8'h14, 32'hff81_0000);
    go(CIDS_OP_UNSIGNED_FIELD_EXTRACT);
    ctl.fieldLsb = 5'h1c;
    ctl.fieldWidthM1 = 5'h03;
    run(32'hf0f0_1234, 32'h0, 32'h0, 32'h0);
    chk(8'h14, 32'h0000_000f);
    ctl.fieldLsb = 5'h00;
    ctl.fieldWidthM1 = 5'h1f;
    wr(8'h10, ctl);
    chk(8'h14, 32'hf0f0_1234);
    $display("test ext done");
  endtask

  task automatic t_mem;
    go(CIDS_OP_STORE_MULTI_DESC);
    ctl.regCount = 5'h03;
    ctl.writeBack = 1'b1;
    run(32'h1000, 32'h0, 32'h0, 32'h0);
    lohi(32'h0ff4, 32'h0ff4);
    ctl.writeBack = 1'b0;
    wr(8'h10, ctl);
    lohi(32'h0ff4, 32'h1000);
    go(CIDS_OP_STORE_DOUBLE_WORD);
    run(32'h100, 32'h8, 32'h0, 32'h0);
    lohi(32'h108, 32'h10c);
    go(CIDS_OP_STORE_EXCL_HALF);
    ctl.exclHeld = 1'b1;
    run(32'h0, 32'hbeef, 32'h0, 32'h0);
    lohi(32'h0, 32'h0001_beef);
    ctl.exclHeld = 1'b0;
    wr(8'h10, ctl);
    chk(8'h14, 32'h1);
    go(CIDS_OP_TABLE_BRANCH_HALF);
    run(32'h2000, 32'h3, 32'h0010, 32'h4000);
    lohi(32'h2006, 32'h4020);
    $display("test mem done");
  endtask

  task automatic t_fp;
    wr(8'h1c, 32'h0);
    go(CIDS_OP_FP_COMPARE);
    run(32'h3f80_0000, 32'h4000_0000, 32'h0, 32'h0);
    chk(8'h1c, 32'h0000_8000);
    run(32'h4000_0000, 32'h3f80_0000, 32'h0, 32'h0);
    chk(8'h1c, 32'h0000_2000);
    run(32'h3f80_0000, 32'h3f80_0000, 32'h0, 32'h0);
    chk(8'h1c, 32'h0000_6000);
    ctl.cmpZero = 1'b1;
    run(32'hbf80_0000, 32'h7f80_0000, 32'h0, 32'h0);
    chk(8'h1c, 32'h0000_8000);
    ctl.cmpZero = 1'b0;
    run(32'h7fc0_0000, 32'h3f80_0000, 32'h0, 32'h0);
    chk(8'h1c, 32'h0000_3000);
    ctl.accum = 1'b1;
    wr(8'h10, ctl);
    chk(8'h1c, 32'h0000_3001);
    wr(8'h1c, 32'hf000_0000);
    go(CIDS_OP_FP_TO_INT);
    run(32'h4040_0000, 32'h0, 32'h0, 32'h0);
    chk(8'h14, 32'h3);
    go(CIDS_OP_INT_TO_FP);
    run(32'h5, 32'h0, 32'h0, 32'h0);
    chk(8'h14, 32'h40a0_0000);
    chk(8'h1c, 32'hf000_0000);
    $display("test fp done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    nrst <= 1'b0;
    {cyc, stb, we, adr, sel, datI} <= '0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_regs();
    t_mul();
    t_lanes();
    t_ext();
    t_mem();
    t_fp();
    summarize();
  end

  // About 600 bus cycles expected; far longer means a hung handshake
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule
